/* File: hdl/power_sequencer.sv */
// Operation
// - Falling power button edge takes the system out of soft-off.
// - Reset button is edge triggered; holding it low does not hold reset.
// - Carrier reset on reset button, supply bad, main low, watchdog, software.
// - Low supply-good input means main power is not good.
// - Suspend-to-RAM indicator low only in suspend-to-RAM.
// - Suspend-to-disk indicator low in suspend-to-disk or soft-off.
// - Soft-off indicator asserted only in soft-off.
// - Default build warns of a coming low-power state via notice pin.
// - Side-bus build drives the shared pin as the side-bus reset.
// - Watchdog output asserted once a watchdog timeout has occurred.
// - General wake and PCIe wake inputs both accepted as wake requests.
// - Low battery-low input reported as battery-low condition.
// - Lid and sleep button activity reported; sleep button sleeps and wakes from suspend-to-RAM.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_cfg.svh"

module power_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int DEBOUNCE = `DEBOUNCE_CYC,
	parameter int RESET_PULSE = `RESET_PULSE_CYC,
	parameter int NOTICE_LEAD = `NOTICE_LEAD_CYC,
	parameter bit SIDE_BUS_MODE = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic power_button_in_n,
	input wire logic reset_button_in_n,
	input wire logic supply_good_in,
	input wire logic main_input_supply_ok,
	input wire logic pcie_wake_in_n,
	input wire logic general_wake_in_n,
	input wire logic battery_low_in_n,
	input wire logic lid_in_n,
	input wire logic sleep_button_in_n,
	input wire logic watchdog_timeout,
	input wire logic watchdog_clear,
	input wire sw_req_t sw_req,
	output logic carrier_reset_out_n,
	output sleep_ind_t sleep_ind,
	output logic side_bus_reset_n,
	output logic watchdog_expired_out,
	output logic battery_low,
	output logic lid_event,
	output logic lid_closed,
	output logic sleep_button_event,
	output logic wake_event,
	output var sys_state_t sys_state
);
	localparam int NW = $clog2(NOTICE_LEAD + 1);

	logic [`IN_COUNT-1:0] raw, clean, fall, rise;
	sys_state_t state, next_state, target, next_target;
	logic [NW-1:0] lead_cnt, next_lead_cnt;
	logic wdt_flag, next_wdt_flag;
	logic lid_ev, next_lid_ev, slp_ev, next_slp_ev, wake_ev, next_wake_ev;
	logic reset_trigger, reset_hold, reset_active;
	logic wake_req, pbtn_edge, sleep_edge;

	always_comb begin
		raw = '1;
		raw[`IDX_POWER_BUTTON_IN_N] = power_button_in_n;
		raw[`IDX_RSTBTN] = reset_button_in_n;
		raw[`IDX_SUPPLY] = supply_good_in;
		raw[`IDX_PCIEWAKE] = pcie_wake_in_n;
		raw[`IDX_GENWAKE] = general_wake_in_n;
		raw[`IDX_BATTERY_LOW_IN_N] = battery_low_in_n;
		raw[`IDX_LID] = lid_in_n;
		raw[`IDX_SLEEP] = sleep_button_in_n;
		raw[`IDX_MAINOK] = main_input_supply_ok;
	end

	input_filter #(
		.WIDTH(`IN_COUNT),
		.SETTLE(DEBOUNCE)
	) u_filter (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.raw(raw),
		.clean(clean),
		.fall(fall),
		.rise(rise)
	);

	assign pbtn_edge = fall[`IDX_POWER_BUTTON_IN_N];
	assign sleep_edge = fall[`IDX_SLEEP];
	assign wake_req = ~clean[`IDX_PCIEWAKE] | ~clean[`IDX_GENWAKE];

	// Reset pulses on the button edge, a software reset request or a watchdog timeout; supply faults hold it for as long as they last.
	assign reset_trigger = fall[`IDX_RSTBTN] | sw_req.reset_req | (watchdog_timeout & ~wdt_flag);
	assign reset_hold = ~clean[`IDX_SUPPLY] | ~clean[`IDX_MAINOK] | (state != st_on);

	pulse_stretch #(
		.LENGTH(RESET_PULSE)
	) u_reset (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.trigger(reset_trigger),
		.hold(reset_hold),
		.active(reset_active)
	);

	always_comb begin
		next_state = state;
		next_target = target;
		next_lead_cnt = lead_cnt;
		case (state)
			st_off: begin
				if (pbtn_edge || wake_req) begin
					next_state = st_powerup;
				end
			end
			st_powerup: begin
				if (clean[`IDX_SUPPLY] && clean[`IDX_MAINOK]) begin
					next_state = st_on;
				end
			end
			st_on: begin
				next_lead_cnt = NW'(NOTICE_LEAD);
				if (!clean[`IDX_SUPPLY] || !clean[`IDX_MAINOK]) begin
					next_state = st_powerup;
				end else if (sw_req.shutdown_req || pbtn_edge) begin
					next_target = st_off;
					next_state = st_notice;
				end else if (sw_req.hibernate_req) begin
					next_target = st_s4;
					next_state = st_notice;
				end else if (sw_req.sleep_req || sleep_edge) begin
					next_target = st_s3;
					next_state = st_notice;
				end
			end
			st_notice: begin
				if (lead_cnt <= NW'(1)) begin
					next_state = target;
				end else begin
					next_lead_cnt = lead_cnt - NW'(1);
				end
			end
			st_s3: begin
				if (wake_req || pbtn_edge || sleep_edge) begin
					next_state = st_powerup;
				end
			end
			st_s4: begin
				if (wake_req || pbtn_edge) begin
					next_state = st_powerup;
				end
			end
			default: begin
				next_state = st_off;
			end
		endcase
	end

	always_comb begin
		next_wdt_flag = wdt_flag;
		if (watchdog_timeout) begin
			next_wdt_flag = 1'b1;
		end else if (watchdog_clear) begin
			next_wdt_flag = 1'b0;
		end
		next_lid_ev = fall[`IDX_LID] | rise[`IDX_LID];
		next_slp_ev = sleep_edge;
		next_wake_ev = (fall[`IDX_PCIEWAKE] | fall[`IDX_GENWAKE]);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= st_off;
			target <= st_off;
			lead_cnt <= '0;
			wdt_flag <= 1'b0;
			lid_ev <= 1'b0;
			slp_ev <= 1'b0;
			wake_ev <= 1'b0;
		end else begin
			state <= next_state;
			target <= next_target;
			lead_cnt <= next_lead_cnt;
			wdt_flag <= next_wdt_flag;
			lid_ev <= next_lid_ev;
			slp_ev <= next_slp_ev;
			wake_ev <= next_wake_ev;
		end
	end

	sleep_ind_t ind, next_ind;
	logic rst_out, next_rst_out, bat, next_bat, lid_c, next_lid_c;

	always_comb begin
		next_ind.suspend_ram_ind_n = ~(next_state == st_s3);
		next_ind.suspend_disk_ind_n = ~(next_state == st_s4 || next_state == st_off);
		next_ind.soft_off_ind_n = ~(next_state == st_off);
		// The shared pin is either the notice or the side-bus reset; only while rstn is low does the side-bus build assert both.
		if (SIDE_BUS_MODE) begin
			next_ind.low_power_soon_n = 1'b1;
		end else begin
			next_ind.low_power_soon_n = ~(next_state == st_notice || next_state == st_s3 ||
				next_state == st_s4 || next_state == st_off);
		end
		next_rst_out = ~reset_active;
		next_bat = ~clean[`IDX_BATTERY_LOW_IN_N];
		next_lid_c = ~clean[`IDX_LID];
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ind <= '{suspend_ram_ind_n: 1'b1, suspend_disk_ind_n: 1'b0, soft_off_ind_n: 1'b0,
				low_power_soon_n: 1'b0};
			rst_out <= 1'b0;
			bat <= 1'b0;
			lid_c <= 1'b0;
		end else begin
			ind <= next_ind;
			rst_out <= next_rst_out;
			bat <= next_bat;
			lid_c <= next_lid_c;
		end
	end

	assign sleep_ind = ind;
	assign side_bus_reset_n = SIDE_BUS_MODE ? rst_out : 1'b1;
	assign carrier_reset_out_n = rst_out;
	assign watchdog_expired_out = wdt_flag;
	assign battery_low = bat;
	assign lid_event = lid_ev;
	assign lid_closed = lid_c;
	assign sleep_button_event = slp_ev;
	assign wake_event = wake_ev;
	assign sys_state = state;
endmodule

`default_nettype wire

/* File: hdl/pwr_seq_cfg.svh */
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

// System clock in kHz.
`define SYS_CLK_KHZ 50000
// Input debounce settle time in microseconds.
`define DEBOUNCE_US 1000
`define DEBOUNCE_CYC ((`DEBOUNCE_US * `SYS_CLK_KHZ) / 1000)
// Least carrier reset pulse in microseconds.
`define RESET_PULSE_US 100
`define RESET_PULSE_CYC (((`RESET_PULSE_US * `SYS_CLK_KHZ) + 999) / 1000)
// Low-power notice lead time in microseconds.
`define NOTICE_LEAD_US 10
`define NOTICE_LEAD_CYC (((`NOTICE_LEAD_US * `SYS_CLK_KHZ) + 999) / 1000)
`define IN_COUNT 9
`define IDX_POWER_BUTTON_IN_N 0
`define IDX_RSTBTN 1
`define IDX_SUPPLY 2
`define IDX_PCIEWAKE 3
`define IDX_GENWAKE 4
`define IDX_BATTERY_LOW_IN_N 5
`define IDX_LID 6
`define IDX_SLEEP 7
`define IDX_MAINOK 8

`endif

/* File: hdl/pwr_seq_pkg.sv */
package pwr_seq_pkg;

	typedef enum logic [2:0] {
		st_off = 3'b000,
		st_powerup = 3'b001,
		st_on = 3'b011,
		st_notice = 3'b010,
		st_s3 = 3'b110,
		st_s4 = 3'b111
	} sys_state_t;

	typedef struct packed {
		logic suspend_ram_ind_n;
		logic suspend_disk_ind_n;
		logic soft_off_ind_n;
		logic low_power_soon_n;
	} sleep_ind_t;

	typedef struct packed {
		logic sleep_req;
		logic hibernate_req;
		logic shutdown_req;
		logic reset_req;
	} sw_req_t;

endpackage

/* File: hdl/input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_cfg.svh"

module input_filter
	import pwr_seq_pkg::*;
#(
	parameter int WIDTH = `IN_COUNT,
	parameter int SETTLE = `DEBOUNCE_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean,
	output logic [WIDTH-1:0] fall,
	output logic [WIDTH-1:0] rise
);
	localparam int CW = $clog2(SETTLE + 1);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_in
			logic meta, sync, level;
			logic [CW-1:0] cnt;
			logic next_level;
			logic [CW-1:0] next_cnt;
			always_comb begin
				next_level = level;
				next_cnt = '0;
				if (sync != level) begin
					if (cnt == CW'(SETTLE - 1)) begin
						next_level = sync;
					end else begin
						next_cnt = cnt + CW'(1);
					end
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					meta <= 1'b1;
					sync <= 1'b1;
					level <= 1'b1;
					cnt <= '0;
				end else begin
					meta <= raw[i];
					sync <= meta;
					level <= next_level;
					cnt <= next_cnt;
				end
			end
			assign clean[i] = level;
			assign fall[i] = level & ~next_level;
			assign rise[i] = ~level & next_level;
		end
	endgenerate
endmodule

`default_nettype wire

/* File: hdl/pulse_stretch.sv */
`timescale 1ns/1ps
`default_nettype none

module pulse_stretch #(
	parameter int LENGTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic trigger,
	input wire logic hold,
	output logic active
);
	localparam int CW = $clog2(LENGTH + 1);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (trigger || hold) begin
			next_cnt = CW'(LENGTH);
		end else if (cnt != '0) begin
			next_cnt = cnt - CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cnt <= CW'(LENGTH);
		end else begin
			cnt <= next_cnt;
		end
	end

	assign active = (cnt != '0);
endmodule

`default_nettype wire

/* File: sim/power_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_properties
	import pwr_seq_pkg::*;
#(
	parameter int RESET_PULSE = 8,
	parameter bit SIDE_BUS_MODE = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic power_button_in_n,
	input wire logic general_wake_in_n,
	input wire logic pcie_wake_in_n,
	input wire logic supply_good_in,
	input wire logic watchdog_timeout,
	input wire logic watchdog_clear,
	input wire logic carrier_reset_out_n,
	input wire sleep_ind_t sleep_ind,
	input wire logic side_bus_reset_n,
	input wire logic watchdog_expired_out,
	input wire sys_state_t sys_state
);
	logic [7:0] low_cnt;
	logic [7:0] next_low_cnt;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// Saturating count of cycles the carrier reset has been low.
	always_comb begin
		next_low_cnt = low_cnt;
		if (carrier_reset_out_n)
			next_low_cnt = 8'h00;
		else if (low_cnt != 8'hff)
			next_low_cnt = low_cnt + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			low_cnt <= 8'h00;
		else
			low_cnt <= next_low_cnt;
	end
	a_pwr_steady_off: assert property (
		(sys_state == st_off && power_button_in_n && general_wake_in_n && pcie_wake_in_n) [*8] |=> sys_state == st_off)
		else $error("Left soft-off without an edge");
	a_reset_pulse_len: assert property ($rose(carrier_reset_out_n) |-> low_cnt >= RESET_PULSE)
		else $error("Carrier reset pulse too short");
	a_supply_bad_reset: assert property (!supply_good_in [*8] |=> !carrier_reset_out_n)
		else $error("Carrier reset high with supply bad");
	a_ram_ind_state: assert property (sleep_ind.suspend_ram_ind_n == (sys_state != st_s3))
		else $error("Suspend-to-RAM indicator wrong");
	a_disk_ind_state: assert property (sleep_ind.suspend_disk_ind_n == !(sys_state inside {st_s4, st_off}))
		else $error("Suspend-to-disk indicator wrong");
	a_off_ind_state: assert property (sleep_ind.soft_off_ind_n == (sys_state != st_off))
		else $error("Soft-off indicator wrong");
	a_notice_before_sleep: assert property (
		$changed(sys_state) && sys_state inside {st_s3, st_s4} |-> $past(sys_state) == st_notice
		&& !$past(sleep_ind.low_power_soon_n)) else $error("Sleep entered without notice");
	a_side_bus_pin: assert property (side_bus_reset_n == (SIDE_BUS_MODE ? carrier_reset_out_n : 1'b1))
		else $error("Shared pin mode wrong");
	a_wdog_set: assert property (watchdog_timeout |-> ##[1:8] watchdog_expired_out)
		else $error("Watchdog flag not set");
	a_wdog_sticky: assert property ((!watchdog_clear) [*3] ##0 watchdog_expired_out |=> watchdog_expired_out)
		else $error("Watchdog flag dropped");
	c_sleep_ram: cover property (sys_state == st_s3);
	c_wdog_flag: cover property ($rose(watchdog_expired_out));
	c_reset_release: cover property ($rose(carrier_reset_out_n));
endmodule
`default_nettype wire

/* File: sim/carrier_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
module carrier_supply_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rail_enable,
	output logic supply_good_in
);
	logic [1:0] ramp;
	logic [1:0] next_ramp;
	// The rail needs three cycles of enable before the supply reports good.
	always_comb begin
		next_ramp = rail_enable ? ramp + {1'b0, ramp != 2'h3} : 2'h0;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			ramp <= 2'h0;
		else
			ramp <= next_ramp;
	end
	assign supply_good_in = (ramp == 2'h3);
endmodule
`default_nettype wire

/* File: sim/module_power_reset_signalling_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module module_power_reset_signalling_tb_top
	import pwr_seq_pkg::*;
;
	typedef struct packed {
		sw_req_t req;
		logic [3:0] press;
		sys_state_t want;
	} row_t;
	logic sys_clk, rstn, reset_button_in_n, main_ok, battery_low_in_n, lid_in_n;
	logic watchdog_timeout, watchdog_clear, supply_good_in, carrier_reset_out_n, side_bus_reset_n;
	logic watchdog_expired_out, battery_low, lid_event, lid_closed;
	logic [3:0] btn_n;
	sw_req_t sw_req;
	sleep_ind_t sleep_ind;
	sys_state_t sys_state;
	int errors, comparisons;
	row_t rows [11];
	power_sequencer #(.DEBOUNCE(4), .RESET_PULSE(8), .NOTICE_LEAD(4), .SIDE_BUS_MODE(1'b0)) dut_u (
		.sys_clk(sys_clk), .rstn(rstn), .power_button_in_n(btn_n[2]), .reset_button_in_n(reset_button_in_n),
		.supply_good_in(supply_good_in), .main_input_supply_ok(main_ok), .pcie_wake_in_n(btn_n[1]),
		.general_wake_in_n(btn_n[0]), .battery_low_in_n(battery_low_in_n), .lid_in_n(lid_in_n),
		.sleep_button_in_n(btn_n[3]), .watchdog_timeout(watchdog_timeout), .watchdog_clear(watchdog_clear),
		.sw_req(sw_req), .carrier_reset_out_n(carrier_reset_out_n), .sleep_ind(sleep_ind),
		.side_bus_reset_n(side_bus_reset_n), .watchdog_expired_out(watchdog_expired_out),
		.battery_low(battery_low), .lid_event(lid_event), .lid_closed(lid_closed), .sleep_button_event(),
		.wake_event(), .sys_state(sys_state));
	carrier_supply_model supply_u (.sys_clk(sys_clk), .rstn(rstn), .supply_good_in(supply_good_in),
		.rail_enable(sleep_ind.soft_off_ind_n & sleep_ind.suspend_ram_ind_n));
	task automatic chk_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_ind(input sys_state_t st);
		comparisons++;
		if (sleep_ind[3:1] !== {st != st_s3, !(st inside {st_s4, st_off}), st != st_off}) begin
			errors++;
			$display("Error at %0t: indicators", $time);
		end
	endtask
	task automatic wait_state(input sys_state_t exp);
		for (int i = 0; i < 100 && sys_state !== exp; i++)
			@(negedge sys_clk);
		comparisons++;
		if (sys_state !== exp) begin
			errors++;
			$display("Error at %0t: state", $time);
		end
	endtask
	task automatic press(input logic [3:0] m);
		@(posedge sys_clk);
		btn_n <= ~m;
		repeat (10) @(posedge sys_clk);
		btn_n <= 4'hf;
		repeat (10) @(posedge sys_clk);
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		errors++;
		$display("Error at %0t: run hung", $time);
		tally_and_finish();
	end
	initial begin
		{errors, comparisons} = '0;
		{rstn, watchdog_timeout, watchdog_clear, sw_req} = '0;
		{btn_n, reset_button_in_n, main_ok, battery_low_in_n, lid_in_n} = '1;
		rows = '{'{4'h0, 4'h4, st_on}, '{4'h8, 4'h0, st_s3}, '{4'h0, 4'h1, st_on}, '{4'h4, 4'h0, st_s4},
			'{4'h0, 4'h2, st_on}, '{4'h0, 4'h8, st_s3}, '{4'h0, 4'h8, st_on}, '{4'h2, 4'h0, st_off},
			'{4'h0, 4'h1, st_on}, '{4'h0, 4'h4, st_off}, '{4'h0, 4'h2, st_on}};
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			@(posedge sys_clk);
			sw_req <= rows[i].req;
			@(posedge sys_clk);
			sw_req <= 4'h0;
			press(rows[i].press);
			wait_state(rows[i].want);
			chk_ind(rows[i].want);
			$display("Row %0d done", i);
		end
		repeat (20) @(negedge sys_clk);
		chk_bit(carrier_reset_out_n, 1'b1, "reset stuck");
		@(posedge sys_clk);
		reset_button_in_n <= 1'b0;
		repeat (12) @(negedge sys_clk);
		chk_bit(carrier_reset_out_n, 1'b0, "no button reset");
		repeat (40) @(negedge sys_clk);
		chk_bit(carrier_reset_out_n, 1'b1, "reset held by level");
		@(posedge sys_clk);
		reset_button_in_n <= 1'b1;
		watchdog_timeout <= 1'b1;
		@(posedge sys_clk);
		watchdog_timeout <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk_bit(watchdog_expired_out, 1'b1, "watchdog flag");
		chk_bit(carrier_reset_out_n, 1'b0, "no watchdog reset");
		@(posedge sys_clk);
		watchdog_clear <= 1'b1;
		sw_req <= 4'h1;
		@(posedge sys_clk);
		{watchdog_clear, sw_req} <= '0;
		repeat (4) @(negedge sys_clk);
		chk_bit(carrier_reset_out_n, 1'b0, "no software reset");
		chk_bit(watchdog_expired_out, 1'b0, "flag not cleared");
		chk_bit(side_bus_reset_n, 1'b1, "shared pin driven as reset");
		@(posedge sys_clk);
		main_ok <= 1'b0;
		battery_low_in_n <= 1'b0;
		lid_in_n <= 1'b0;
		for (int i = 0; i < 20 && lid_event !== 1'b1; i++)
			@(negedge sys_clk);
		chk_bit(lid_event, 1'b1, "lid event");
		repeat (6) @(negedge sys_clk);
		chk_bit(carrier_reset_out_n, 1'b0, "main low ignored");
		chk_bit(battery_low, 1'b1, "battery low");
		chk_bit(lid_closed, 1'b1, "lid level");
		$display("Edge and status tests done");
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		wait_state(st_off);
		chk_ind(st_off);
		chk_bit(watchdog_expired_out, 1'b0, "flag after reset");
		chk_bit(sleep_ind.low_power_soon_n, 1'b0, "notice in soft-off");
		$display("Reset test done");
		tally_and_finish();
	end
endmodule
bind power_sequencer power_sequencer_properties #(.RESET_PULSE(RESET_PULSE), .SIDE_BUS_MODE(SIDE_BUS_MODE)) checker_u (
	.sys_clk(sys_clk), .rstn(rstn), .power_button_in_n(power_button_in_n), .general_wake_in_n(general_wake_in_n),
	.pcie_wake_in_n(pcie_wake_in_n), .supply_good_in(supply_good_in), .watchdog_timeout(watchdog_timeout),
	.watchdog_clear(watchdog_clear), .carrier_reset_out_n(carrier_reset_out_n), .sleep_ind(sleep_ind),
	.side_bus_reset_n(side_bus_reset_n), .watchdog_expired_out(watchdog_expired_out), .sys_state(sys_state));
`default_nettype wire
